// [core/ddc_fe_map.svh]
// Register map, field positions and fixed constants of the front end
`ifndef DDC_FE_MAP_SVH
`define DDC_FE_MAP_SVH
`define ADR_CH_CFG     16'h0000
`define ADR_PN_GAIN    16'h0001
`define ADR_NCO_CFG    16'h0004
`define ADR_FREQ_HOLD  16'h0005
`define ADR_FREQ_LOAD  16'h0006
`define ADR_FREQ_ACT   16'h0007
`define ADR_TEST_CTL   16'hf800
`define ADR_LD_SRC     16'hf804
`define ADR_LD_CFG     16'hf805
`define ADR_LD_START   16'hf806
`define ADR_LD_RESULT  16'hf808
`define CH_FMT_MSB     2
`define CH_FMT_LSB     0
`define CH_SRC_MSB     4
`define CH_SRC_LSB     3
`define CH_OFS_EN      5
`define NCO_SYNC_EN    0
`define NCO_ZERO_PH    1
`define TEST_PN_EN     0
`define TEST_PN_MSB    2
`define TEST_PN_LSB    1
`define LD_SRC_MSB     1
`define LD_SRC_LSB     0
`define LD_FMT_MSB     4
`define LD_FMT_LSB     2
`define LD_CNT_MSB     15
`define LD_CNT_LSB     0
`define LD_MTH_MSB     17
`define LD_MTH_LSB     16
`define LD_LEAK_MSB    19
`define LD_LEAK_LSB    18
`define LD_CONT        20
`define LD_CNT_BIAS    17'h00002
`define LEAK_SH_A1     5'h00
`define LEAK_SH_A8     5'h08
`define LEAK_SH_A12    5'h0c
`define LEAK_SH_A16    5'h10
`define OFS_DATA_BIT   0
`define OFS_FRAME_BIT  1
`define PN_Q_TAP       7
`define PN_SEED15      15'h0001
`define PN_SEED23      23'h000001
`define EXP_MAX_11     3'h5
`define EXP_MAX_12     3'h4
`define EXP_MAX_13     3'h3
`define EXP_MAX_14     3'h2
`define OFFS_FLIP      16'h8000
`define QUARTER_TURN   24'h400000
`define SIN_PEAK       19'h3ffff
`endif

// [core/ddc_fe_pkg.sv]
// Types shared by the front end design files
package ddc_fe_pkg;
   typedef enum logic [2:0] {
      FMT_TWOS = 3'h0,
      FMT_OFFS = 3'h1,
      FMT_FL11 = 3'h2,
      FMT_FL12 = 3'h3,
      FMT_FL13 = 3'h4,
      FMT_FL14 = 3'h5
   } fmt_t;
   typedef enum logic [1:0] {
      LDM_INTEG = 2'h0,
      LDM_PEAK  = 2'h1,
      LDM_LEAKY = 2'h2
   } ldm_t;
   typedef enum logic [1:0] {
      PN_LEN15   = 2'h0,
      PN_LEN23   = 2'h1,
      PN_LENPROD = 2'h2
   } pn_len_t;
   typedef enum logic [1:0] {
      LD_IDLE = 2'b01,
      LD_RUN  = 2'b10
   } ld_state_t;
endpackage : ddc_fe_pkg

// [core/sample_format.sv]
// Input word formatter: fixed point and gain-ranging floating point maps
`timescale 1ns/1ns
`include "ddc_fe_map.svh"
module sample_format #(
   parameter int W = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [W-1:0]     raw,
   input  wire ddc_fe_pkg::fmt_t fmt,
   output logic [W-1:0]          fmt_out
);
   if (W != 16) begin : g_width_chk
      $error("sample_format is built for 16-bit words only");
   end

   function automatic logic [2:0] sat_shift(input logic [2:0] e,
                                             input logic [2:0] emax);
      sat_shift = emax - ((e > emax) ? emax : e);
   endfunction : sat_shift

   wire               exponent_bit_high = raw[2];
   wire               exponent_bit_mid  = raw[1];
   wire               exponent_bit_low  = raw[0];
   wire [2:0]         exp3 = {exponent_bit_high, exponent_bit_mid,
                              exponent_bit_low};
   wire [2:0]         exp_pair = {1'b0, exponent_bit_mid, exponent_bit_low};
   // Exponent bits are masked off so they never reach the mantissa
   wire signed [15:0] man13 = {raw[15:3], 3'h0};
   wire signed [15:0] man14 = {raw[15:2], 2'h0};
   wire [15:0]        fl11 = man13 >>> sat_shift(exp3, `EXP_MAX_11);
   wire [15:0]        fl12 = man13 >>> sat_shift(exp3, `EXP_MAX_12);
   wire [15:0]        fl13 = man13 >>> sat_shift(exp3, `EXP_MAX_13);
   wire [15:0]        fl14 = man14 >>> sat_shift(exp_pair, `EXP_MAX_14);
   wire [15:0]        fmt_out_nxt =
      (fmt == ddc_fe_pkg::FMT_OFFS) ? raw ^ `OFFS_FLIP :
      (fmt == ddc_fe_pkg::FMT_FL11) ? fl11 :
      (fmt == ddc_fe_pkg::FMT_FL12) ? fl12 :
      (fmt == ddc_fe_pkg::FMT_FL13) ? fl13 :
      (fmt == ddc_fe_pkg::FMT_FL14) ? fl14 : raw;

   // One register for every format keeps the latency fixed
   always_ff @(posedge clk) begin
      if (rst) fmt_out <= '0;
      else     fmt_out <= fmt_out_nxt;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_fl11_sat;
      fmt == ddc_fe_pkg::FMT_FL11 && exp3 > `EXP_MAX_11
         |=> fmt_out == ($past(raw) & 16'hfff8);
   endproperty
   a_fl11_sat: assert property (p_fl11_sat)
      else $error("11-bit exponent not clamped at 101");
   property p_fl11_zero;
      fmt == ddc_fe_pkg::FMT_FL11 && exp3 == 3'h0
         |=> fmt_out == 16'($signed($past(raw)) >>> 5);
   endproperty
   a_fl11_zero: assert property (p_fl11_zero)
      else $error("11-bit exponent zero map wrong");
   property p_fl12_zero;
      fmt == ddc_fe_pkg::FMT_FL12 && exp3 == 3'h0
         |=> fmt_out == 16'($signed($past(raw)) >>> 4);
   endproperty
   a_fl12_zero: assert property (p_fl12_zero)
      else $error("12-bit exponent zero map wrong");
   property p_fl13_sat;
      fmt == ddc_fe_pkg::FMT_FL13 && exp3 > `EXP_MAX_13
         |=> fmt_out == ($past(raw) & 16'hfff8);
   endproperty
   a_fl13_sat: assert property (p_fl13_sat)
      else $error("13-bit exponent not clamped at 011");
   property p_fl14_sat;
      fmt == ddc_fe_pkg::FMT_FL14 && exp_pair == 3'h3
         |=> fmt_out == ($past(raw) & 16'hfffc);
   endproperty
   a_fl14_sat: assert property (p_fl14_sat)
      else $error("14-bit exponent not clamped at 10");
   property p_fixed;
      fmt == ddc_fe_pkg::FMT_TWOS |=> fmt_out == $past(raw);
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed point latency wrong");
   c_fl11_sat: cover property (p_fl11_sat);
endmodule : sample_format

// [core/ddc_front_end.sv]
// Downconverter front end: formatter, level detector, NCO, mixer, noise
`timescale 1ns/1ns
`include "ddc_fe_map.svh"
module ddc_front_end #(
   parameter int IW = 16,
   parameter int OW = 24
) (
   input  wire logic          MCLK,
   input  wire logic          RESET,
   input  wire logic [IW-1:0] BUS_A,
   input  wire logic [IW-1:0] BUS_B,
   input  wire logic [IW-1:0] BUS_C,
   input  wire logic [IW-1:0] BUS_D,
   input  wire logic          SYNC_IN_STROBE,
   input  wire logic          WR_STROBE,
   input  wire logic [15:0]   ADDRESS,
   input  wire logic [31:0]   WR_DATA,
   output logic [31:0]        RD_DATA,
   output logic [OW-1:0]      I_OUT,
   output logic [OW-1:0]      Q_OUT
);
   if (IW != 16 || OW != 24) begin : g_width_chk
      $error("ddc_front_end needs 16-bit inputs and 24-bit outputs");
   end

   function automatic logic [15:0] bus_pick(input logic [1:0] s,
      input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] c, input logic [15:0] d);
      bus_pick = (s == 2'h0) ? a : (s == 2'h1) ? b : (s == 2'h2) ? c : d;
   endfunction : bus_pick

   // Parabolic sine: cheap, but its purity is far below a table
   function automatic logic signed [18:0] sin_q(input logic [23:0] p);
      logic [22:0] x;
      logic [45:0] prod;
      logic [18:0] lim;
      x = p[22:0];
      prod = x * 23'(~x);
      lim = prod[44] ? `SIN_PEAK : prod[44:26];
      sin_q = p[23] ? -$signed(lim) : $signed(lim);
   endfunction : sin_q

   function automatic logic pn_pick(input ddc_fe_pkg::pn_len_t m,
                                    input logic a, input logic b);
      pn_pick = (m == ddc_fe_pkg::PN_LEN15) ? a :
                (m == ddc_fe_pkg::PN_LEN23) ? b : a ^ b;
   endfunction : pn_pick

   function automatic logic [23:0] pn_word(input logic s,
                                           input logic [15:0] g);
      pn_word = {s, s, s, g, 5'h00};
   endfunction : pn_word

   // Configuration registers
   logic [5:0]  ch_cfg_r;
   logic [15:0] pn_gain_r;
   logic [1:0]  nco_cfg_r;
   logic [31:0] freq_hold_r;
   logic [31:0] freq_act_r;
   logic [2:0]  test_ctl_r;
   logic [4:0]  ld_src_r;
   logic [20:0] ld_cfg_r;

   wire wr_ch_cfg  = WR_STROBE && ADDRESS == `ADR_CH_CFG;
   wire wr_pn_gain = WR_STROBE && ADDRESS == `ADR_PN_GAIN;
   wire wr_nco_cfg = WR_STROBE && ADDRESS == `ADR_NCO_CFG;
   wire wr_hold    = WR_STROBE && ADDRESS == `ADR_FREQ_HOLD;
   wire wr_load    = WR_STROBE && ADDRESS == `ADR_FREQ_LOAD;
   wire wr_test    = WR_STROBE && ADDRESS == `ADR_TEST_CTL;
   wire wr_ld_src  = WR_STROBE && ADDRESS == `ADR_LD_SRC;
   wire wr_ld_cfg  = WR_STROBE && ADDRESS == `ADR_LD_CFG;
   wire ld_start   = WR_STROBE && ADDRESS == `ADR_LD_START;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ch_cfg_r    <= '0;
         pn_gain_r   <= '0;
         nco_cfg_r   <= '0;
         freq_hold_r <= '0;
         test_ctl_r  <= '0;
         ld_src_r    <= '0;
         ld_cfg_r    <= '0;
      end else begin
         if (wr_ch_cfg)  ch_cfg_r    <= WR_DATA[5:0];
         if (wr_pn_gain) pn_gain_r   <= WR_DATA[15:0];
         if (wr_nco_cfg) nco_cfg_r   <= WR_DATA[1:0];
         if (wr_hold)    freq_hold_r <= WR_DATA;
         if (wr_test)    test_ctl_r  <= WR_DATA[2:0];
         if (wr_ld_src)  ld_src_r    <= WR_DATA[4:0];
         if (wr_ld_cfg)  ld_cfg_r    <= WR_DATA[20:0];
      end
   end

   // Input selection and formatting for the channel and the detector
   logic [15:0] ch_fmt;
   logic [15:0] ld_fmt;
   wire [15:0] ch_raw = bus_pick(ch_cfg_r[`CH_SRC_MSB:`CH_SRC_LSB],
                                 BUS_A, BUS_B, BUS_C, BUS_D);
   wire [15:0] ld_raw = bus_pick(ld_src_r[`LD_SRC_MSB:`LD_SRC_LSB],
                                 BUS_A, BUS_B, BUS_C, BUS_D);

   sample_format #(.W(16)) u_ch_fmt (
      .clk     (MCLK),
      .rst     (RESET),
      .raw     (ch_raw),
      .fmt     (ddc_fe_pkg::fmt_t'(ch_cfg_r[`CH_FMT_MSB:`CH_FMT_LSB])),
      .fmt_out (ch_fmt)
   );
   sample_format #(.W(16)) u_ld_fmt (
      .clk     (MCLK),
      .rst     (RESET),
      .raw     (ld_raw),
      .fmt     (ddc_fe_pkg::fmt_t'(ld_src_r[`LD_FMT_MSB:`LD_FMT_LSB])),
      .fmt_out (ld_fmt)
   );

   // Level detector
   ddc_fe_pkg::ld_state_t ld_state_r, ld_state_nxt;
   logic [16:0] ld_cnt_r, ld_cnt_nxt;
   logic [31:0] ld_acc_r, ld_acc_nxt;
   logic [31:0] ld_res_r, ld_res_nxt;

   wire ddc_fe_pkg::ldm_t ld_mth =
      ddc_fe_pkg::ldm_t'(ld_cfg_r[`LD_MTH_MSB:`LD_MTH_LSB]);
   wire [1:0]  ld_leak_sel = ld_cfg_r[`LD_LEAK_MSB:`LD_LEAK_LSB];
   wire [4:0]  ld_leak_sh  = (ld_leak_sel == 2'h0) ? `LEAK_SH_A1 :
                             (ld_leak_sel == 2'h1) ? `LEAK_SH_A8 :
                             (ld_leak_sel == 2'h2) ? `LEAK_SH_A12 :
                             `LEAK_SH_A16;
   // Integrated magnitude has a defined end only, never continuous
   wire ld_cont = ld_cfg_r[`LD_CONT] && ld_mth != ddc_fe_pkg::LDM_INTEG;
   wire [16:0] ld_cnt_load = 17'({1'b0,
      ld_cfg_r[`LD_CNT_MSB:`LD_CNT_LSB]} + `LD_CNT_BIAS);
   wire [15:0] ld_mag = ld_fmt[15] ? 16'(-ld_fmt) : ld_fmt;
   wire [31:0] ld_mag32 = {16'h0000, ld_mag};
   wire signed [32:0] ld_diff = $signed({1'b0, ld_mag, 16'h0000}) -
                                $signed({1'b0, ld_acc_r});
   wire signed [32:0] ld_step = ld_diff >>> ld_leak_sh;
   wire [31:0] ld_upd =
      (ld_mth == ddc_fe_pkg::LDM_PEAK) ?
         ((ld_mag32 > ld_acc_r) ? ld_mag32 : ld_acc_r) :
      (ld_mth == ddc_fe_pkg::LDM_LEAKY) ? ld_acc_r + ld_step[31:0] :
      ld_acc_r + ld_mag32;
   wire ld_run  = ld_state_r == ddc_fe_pkg::LD_RUN;
   wire ld_last = ld_run && ld_cnt_r == 17'h00001;

   always_comb begin
      ld_state_nxt = ld_state_r;
      ld_cnt_nxt   = ld_cnt_r;
      ld_acc_nxt   = ld_acc_r;
      ld_res_nxt   = ld_res_r;
      case (ld_state_r)
         ddc_fe_pkg::LD_IDLE: begin
            ld_state_nxt = ddc_fe_pkg::LD_IDLE;
         end
         ddc_fe_pkg::LD_RUN: begin
            ld_acc_nxt = ld_upd;
            ld_cnt_nxt = ld_cnt_r - 17'h00001;
            if (ld_cont) ld_res_nxt = ld_upd;
            if (ld_last) begin
               ld_res_nxt = ld_upd;
               if (ld_cont) ld_cnt_nxt = ld_cnt_load;
               else ld_state_nxt = ddc_fe_pkg::LD_IDLE;
            end
         end
         default: ld_state_nxt = ddc_fe_pkg::LD_IDLE;
      endcase
      if (ld_start) begin
         ld_state_nxt = ddc_fe_pkg::LD_RUN;
         ld_cnt_nxt   = ld_cnt_load;
         ld_acc_nxt   = '0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ld_state_r <= ddc_fe_pkg::LD_IDLE;
         ld_cnt_r   <= '0;
         ld_acc_r   <= '0;
         ld_res_r   <= '0;
      end else begin
         ld_state_r <= ld_state_nxt;
         ld_cnt_r   <= ld_cnt_nxt;
         ld_acc_r   <= ld_acc_nxt;
         ld_res_r   <= ld_res_nxt;
      end
   end

   // Carrier NCO with double-buffered frequency
   logic [31:0] phase_r;
   logic [31:0] ofs_sh_r;
   logic [31:0] ofs_r;
   wire freq_load = wr_load ||
      (SYNC_IN_STROBE && nco_cfg_r[`NCO_SYNC_EN]);
   wire ofs_en = ch_cfg_r[`CH_OFS_EN];
   wire [31:0] ofs_shift = {ofs_sh_r[30:0], BUS_D[`OFS_DATA_BIT]};
   wire [31:0] phase_step = freq_act_r + (ofs_en ? ofs_r : 32'h0);

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         freq_act_r <= '0;
         phase_r    <= '0;
         ofs_sh_r   <= '0;
         ofs_r      <= '0;
      end else begin
         if (freq_load) freq_act_r <= freq_hold_r;
         if (freq_load && nco_cfg_r[`NCO_ZERO_PH])
            phase_r <= '0;
         else
            phase_r <= phase_r + phase_step;
         if (ofs_en) ofs_sh_r <= ofs_shift;
         if (ofs_en && BUS_D[`OFS_FRAME_BIT]) ofs_r <= ofs_shift;
      end
   end

   // Mixer: top 24 bits of the 16 x 19 product
   wire [23:0] nco_ph = phase_r[31:8];
   wire signed [18:0] nco_cos = sin_q(nco_ph + `QUARTER_TURN);
   wire signed [18:0] nco_sin = sin_q(nco_ph);
   wire signed [34:0] prod_i = $signed(ch_fmt) * nco_cos;
   wire signed [34:0] prod_q = $signed(ch_fmt) * nco_sin;
   logic [23:0] mix_i_r;
   logic [23:0] mix_q_r;

   // Pseudonoise
   logic [14:0] lfsr15_r;
   logic [22:0] lfsr23_r;
   wire ddc_fe_pkg::pn_len_t pn_len =
      ddc_fe_pkg::pn_len_t'(test_ctl_r[`TEST_PN_MSB:`TEST_PN_LSB]);
   wire pn_on = test_ctl_r[`TEST_PN_EN] && pn_gain_r != 16'h0000;
   // Q taps a later stage of each register, a fixed time offset
   wire pn_i_bit = pn_pick(pn_len, lfsr15_r[0], lfsr23_r[0]);
   wire pn_q_bit = pn_pick(pn_len, lfsr15_r[`PN_Q_TAP],
                           lfsr23_r[`PN_Q_TAP]);
   wire [23:0] pn_i = pn_on ? pn_word(pn_i_bit, pn_gain_r) : 24'h0;
   wire [23:0] pn_q = pn_on ? pn_word(pn_q_bit, pn_gain_r) : 24'h0;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         lfsr15_r <= `PN_SEED15;
         lfsr23_r <= `PN_SEED23;
         mix_i_r  <= '0;
         mix_q_r  <= '0;
         I_OUT    <= '0;
         Q_OUT    <= '0;
      end else begin
         if (test_ctl_r[`TEST_PN_EN]) begin
            lfsr15_r <= {lfsr15_r[13:0], lfsr15_r[14] ^ lfsr15_r[13]};
            lfsr23_r <= {lfsr23_r[21:0], lfsr23_r[22] ^ lfsr23_r[17]};
         end
         mix_i_r <= prod_i[33:10];
         mix_q_r <= prod_q[33:10];
         I_OUT   <= mix_i_r + pn_i;
         Q_OUT   <= mix_q_r + pn_q;
      end
   end

   // Read-back, one cycle after the address
   wire [31:0] rd_w =
      (ADDRESS == `ADR_CH_CFG)    ? 32'(ch_cfg_r)   :
      (ADDRESS == `ADR_PN_GAIN)   ? 32'(pn_gain_r)  :
      (ADDRESS == `ADR_NCO_CFG)   ? 32'(nco_cfg_r)  :
      (ADDRESS == `ADR_FREQ_HOLD) ? freq_hold_r     :
      (ADDRESS == `ADR_FREQ_ACT)  ? freq_act_r      :
      (ADDRESS == `ADR_TEST_CTL)  ? 32'(test_ctl_r) :
      (ADDRESS == `ADR_LD_SRC)    ? 32'(ld_src_r)   :
      (ADDRESS == `ADR_LD_CFG)    ? 32'(ld_cfg_r)   :
      (ADDRESS == `ADR_LD_RESULT) ? ld_res_r : 32'h0;

   always_ff @(posedge MCLK) begin
      if (RESET) RD_DATA <= '0;
      else       RD_DATA <= rd_w;
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   property p_freq_load;
      freq_load |=> freq_act_r == $past(freq_hold_r);
   endproperty
   a_freq_load: assert property (p_freq_load)
      else $error("active frequency not loaded");
   property p_phase_zero;
      freq_load && nco_cfg_r[`NCO_ZERO_PH] |=> phase_r == 32'h0;
   endproperty
   a_phase_zero: assert property (p_phase_zero)
      else $error("phase not cleared on load");
   property p_pn_off;
      pn_gain_r == 16'h0000 |=> I_OUT == $past(mix_i_r);
   endproperty
   a_pn_off: assert property (p_pn_off)
      else $error("noise added with zero gain");
   property p_pn_word;
      pn_on && pn_i_bit
         |=> I_OUT == $past(mix_i_r) + {3'h7, $past(pn_gain_r), 5'h00};
   endproperty
   a_pn_word: assert property (p_pn_word)
      else $error("noise word layout wrong");
   property p_ld_load;
      ld_start |=> ld_run && ld_cnt_r == 17'(
         {1'b0, $past(ld_cfg_r[`LD_CNT_MSB:`LD_CNT_LSB])} + 17'h00002);
   endproperty
   a_ld_load: assert property (p_ld_load)
      else $error("interval count not loaded");
   property p_ld_result;
      ld_last && !ld_cont && !ld_start
         |=> ld_res_r == $past(ld_upd) && !ld_run;
   endproperty
   a_ld_result: assert property (p_ld_result)
      else $error("result not captured at interval end");
   property p_ld_peak;
      ld_run && ld_mth == ddc_fe_pkg::LDM_PEAK && !ld_start
         |=> ld_acc_r >= $past(ld_acc_r);
   endproperty
   a_ld_peak: assert property (p_ld_peak)
      else $error("peak value fell");
   property p_lfsr_live;
      test_ctl_r[`TEST_PN_EN] |-> lfsr15_r != 15'h0 && lfsr23_r != 23'h0;
   endproperty
   a_lfsr_live: assert property (p_lfsr_live)
      else $error("noise generator stuck at zero");

   c_sync_load: cover property (SYNC_IN_STROBE && nco_cfg_r[0]);
   c_ld_done: cover property (ld_last ##1 !ld_run);
   c_pn_on: cover property (pn_on [*3]);
endmodule : ddc_front_end

// [tb/adc_model.sv]
// Converter model that drives the four parallel sample buses
`timescale 1ns/1ns
module adc_model (
   input  wire logic        clk,
   input  wire logic [15:0] code,
   input  wire logic [1:0]  sel,
   output logic [15:0]      bus_a,
   output logic [15:0]      bus_b,
   output logic [15:0]      bus_c,
   output logic [15:0]      bus_d
);
   logic [15:0] pat;
   // Unselected buses churn every cycle, so a wrong source pick shows
   initial begin
      pat = 16'h1357;
      bus_a = 16'h0000;
      bus_b = 16'h0000;
      bus_c = 16'h0000;
      bus_d = 16'h0000;
   end
   // Small delay keeps bus changes clear of the sampling edge
   always @(posedge clk) begin
      #2;
      pat = pat + 16'h3c5b;
      bus_a = (sel == 2'h0) ? code : pat;
      bus_b = (sel == 2'h1) ? code : ~pat;
      bus_c = (sel == 2'h2) ? code : pat ^ 16'h5a5a;
      bus_d = (sel == 2'h3) ? code : pat + 16'h0101;
   end
endmodule : adc_model

// [tb/ddc_front_end_bench.sv]
// Self-checking bench for the downconverter front end
`timescale 1ns/1ns
`include "ddc_fe_map.svh"
module ddc_front_end_bench;
   typedef struct {
      ddc_fe_pkg::fmt_t fmt;
      logic [1:0]       src;
      logic [15:0]      code;
      logic [31:0]      peak;
   } row_t;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        sync_in_strobe = 1'b0;
   logic        wr_strobe = 1'b0;
   logic [15:0] address = 16'h0000;
   logic [31:0] wr_data = 32'h0;
   logic [15:0] code = 16'h0000;
   logic [1:0]  sel = 2'h0;
   logic [15:0] bus_a, bus_b, bus_c, bus_d;
   logic [31:0] rd_data;
   logic [23:0] i_out, q_out;
   logic [31:0] v;
   int          err_count = 0;
   int          compares = 0;
   int          n, m, ones, diff;
   row_t        rows [13];

   adc_model adc_model_inst (.clk(mclk), .code(code), .sel(sel),
      .bus_a(bus_a), .bus_b(bus_b), .bus_c(bus_c), .bus_d(bus_d));
   ddc_front_end ddc_front_end_inst (.MCLK(mclk), .RESET(reset),
      .BUS_A(bus_a), .BUS_B(bus_b), .BUS_C(bus_c), .BUS_D(bus_d),
      .SYNC_IN_STROBE(sync_in_strobe), .WR_STROBE(wr_strobe),
      .ADDRESS(address), .WR_DATA(wr_data), .RD_DATA(rd_data),
      .I_OUT(i_out), .Q_OUT(q_out));

   always #25 mclk = ~mclk;

   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #5;
   endtask : step
   // Strobe drops for a full cycle so back-to-back calls never glitch
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      address = a;
      wr_data = d;
      wr_strobe = 1'b1;
      step(1);
      wr_strobe = 1'b0;
      step(1);
   endtask : wr
   task automatic rd(input logic [15:0] a);
      address = a;
      step(1);
      v = rd_data;
   endtask : rd
   task automatic measure(input logic [31:0] s, input logic [31:0] c,
                          input int k);
      wr(`ADR_LD_SRC, s);
      wr(`ADR_LD_CFG, c);
      wr(`ADR_LD_START, 32'h1);
      step(k);
      rd(`ADR_LD_RESULT);
   endtask : measure
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t reg got %h want %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_smp(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t sample got %h want %h", $time, got, exp);
      end
   endtask : chk_smp
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   initial begin
      repeat (90000) @(posedge mclk);
      err_count++;
      end_sim;
   end

   initial begin
      rows = '{
         '{ddc_fe_pkg::FMT_TWOS, 2'h0, 16'h1234, 32'h1234},
         '{ddc_fe_pkg::FMT_TWOS, 2'h1, 16'hc001, 32'h3fff},
         '{ddc_fe_pkg::FMT_OFFS, 2'h2, 16'h0100, 32'h7f00},
         '{ddc_fe_pkg::FMT_FL11, 2'h3, 16'h7ffd, 32'h7ff8},
         '{ddc_fe_pkg::FMT_FL11, 2'h0, 16'h8016, 32'h7ff0},
         '{ddc_fe_pkg::FMT_FL11, 2'h1, 16'h4000, 32'h0200},
         '{ddc_fe_pkg::FMT_FL12, 2'h2, 16'h7ff5, 32'h7ff0},
         '{ddc_fe_pkg::FMT_FL12, 2'h3, 16'hf00b, 32'h07fc},
         '{ddc_fe_pkg::FMT_FL12, 2'h0, 16'h8000, 32'h0800},
         '{ddc_fe_pkg::FMT_FL13, 2'h0, 16'h7ff4, 32'h7ff0},
         '{ddc_fe_pkg::FMT_FL13, 2'h1, 16'h5551, 32'h1554},
         '{ddc_fe_pkg::FMT_FL14, 2'h2, 16'h7ffb, 32'h7ff8},
         '{ddc_fe_pkg::FMT_FL14, 2'h3, 16'ha001, 32'h3000}};
      step(6);
      reset = 1'b0;
      step(1);
      rd(`ADR_LD_CFG);
      chk_reg(v, 32'h0);
      rd(`ADR_FREQ_ACT);
      chk_reg(v, 32'h0);
      rd(16'h1234);
      chk_reg(v, 32'h0);
      chk_smp(i_out, 24'h0);
      $display("reset test done");
      // Peak of a steady word equals the magnitude of its mapping
      for (n = 0; n < 13; n++) begin
         sel = rows[n].src;
         code = rows[n].code;
         measure({27'h0, rows[n].fmt, rows[n].src}, 32'h10000, 8);
         chk_reg(v, rows[n].peak);
      end
      $display("format table done");
      sel = 2'h0;
      code = 16'h0001;
      measure(32'h0, 32'h0, 8);
      chk_reg(v, 32'h2);
      measure(32'h0, 32'hffff, 65545);
      chk_reg(v, 32'h10001);
      code = 16'h0040;
      measure(32'h0, 32'h20000, 8);
      chk_reg(v, 32'h400000);
      // A of 2^-8: first output x*A, second x*A plus (1-A) of the first
      code = 16'h0100;
      measure(32'h0, 32'h60000, 8);
      chk_reg(v, 32'h1ff00);
      code = 16'h0010;
      measure(32'h0, 32'h110000, 8);
      chk_reg(v, 32'h10);
      code = 16'h0200;
      step(6);
      rd(`ADR_LD_RESULT);
      chk_reg(v, 32'h200);
      $display("detector test done");
      wr(`ADR_FREQ_HOLD, 32'h12345678);
      rd(`ADR_FREQ_ACT);
      chk_reg(v, 32'h0);
      wr(`ADR_FREQ_LOAD, 32'h0);
      rd(`ADR_FREQ_ACT);
      chk_reg(v, 32'h12345678);
      for (m = 0; m < 2; m++) begin
         wr(`ADR_FREQ_HOLD, 32'h9abcdef0);
         // Second pass also asks for the phase restart on load
         wr(`ADR_NCO_CFG, 32'(m * 3));
         sync_in_strobe = 1'b1;
         step(1);
         sync_in_strobe = 1'b0;
         step(2);
         rd(`ADR_FREQ_ACT);
         chk_reg(v, m ? 32'h9abcdef0 : 32'h12345678);
      end
      $display("carrier load test done");
      // Zero input makes the mix zero, leaving only the noise word
      code = 16'h0000;
      wr(`ADR_TEST_CTL, 32'h1);
      step(4);
      chk_smp(i_out, 24'h0);
      chk_smp(q_out, 24'h0);
      wr(`ADR_PN_GAIN, 32'hffff);
      for (m = 0; m < 3; m++) begin
         wr(`ADR_TEST_CTL, 32'h1 | (m << 1));
         step(4);
         ones = 0;
         diff = 0;
         for (n = 0; n < 60; n++) begin
            chk_smp(i_out, {{3{i_out[23]}}, 21'h1fffe0});
            ones += (i_out[23] === 1'b1);
            diff += (i_out[23] !== q_out[23]);
            step(1);
         end
         chk_reg({ones > 0, ones < 60, diff > 0}, 32'h7);
      end
      wr(`ADR_PN_GAIN, 32'h0);
      step(4);
      chk_smp(i_out, 24'h0);
      $display("noise test done");
      // Zero frequency after a phase restart parks the carrier at the
      // cosine peak, so I is the input times the sine peak, Q is zero
      wr(`ADR_FREQ_HOLD, 32'h0);
      wr(`ADR_FREQ_LOAD, 32'h0);
      code = 16'h1000;
      step(6);
      chk_smp(i_out, 24'h0ffffc);
      chk_smp(q_out, 24'h0);
      $display("mixer test done");
      // A second reset in mid-run must clear what was written
      reset = 1'b1;
      step(2);
      reset = 1'b0;
      step(1);
      chk_smp(i_out, 24'h0);
      rd(`ADR_LD_CFG);
      chk_reg(v, 32'h0);
      rd(`ADR_LD_RESULT);
      chk_reg(v, 32'h0);
      $display("second reset test done");
      end_sim;
   end
endmodule : ddc_front_end_bench
